// ===== rtl/zgod_decoder.sv
// Purpose: Decode the cyclic output image written by the fieldbus master
// Assumes: Master writes the image over Avalon-MM, validity byte last
// Notes:   Orders start on a zero to nonzero change of the validity byte
//
// Functional notes
// - Group code n addresses zones 8n-7 to 8n
// - Group code zero addresses global settings
// - Parameter selector carries parameter number
// - Code 0 setpoint, 1 to 251 controller parameters
// - Code 252 heater current, 253 rate
// - Code 254 actual value, 255 status
// - Validity byte holds eight dataword flags
// - Dataword used only when its flag set
// - Bit0 is word one, bit7 word eight
// - Order applies only to flagged zones
// - Read orders ignore all datawords
// - Order code 1 reads, 2 sends
// - Datawords stored low byte first
`timescale 1ns/1ps
`default_nettype none
`include "zgod_regs.svh"

module zgod_decoder
    import zgod_pkg::*;
#(
    parameter int ZONE_W = 11
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic [`ZGOD_ADDR_W-1:0]  avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output var  logic [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    output var  logic                     cmd_valid,
    output var  zgod_cmd_s                cmd
);

    // ======================================================
    // Elaboration check
    if (ZONE_W != 11) begin : g_bad_width
        $error("zone base width must be 11");
    end

    // ======================================================
    // Storage
    logic [31:0]      header;
    logic [3:0][31:0] word_pairs;
    logic             ack;
    logic             pend;
    logic             order_err;
    logic [7:0]       last_order;
    logic [7:0]       exec_cnt;
    logic             wr_acc;
    logic             rd_req;
    logic [7:0]       new_valid;
    logic             trig;

    // Merge write data under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Map parameter selector to its kind
    function automatic zgod_param_e param_kind(input logic [7:0] p);
        zgod_param_e k;
        k = ZGOD_PK_CTRL;
        unique case (p)
            `ZGOD_PAR_SETPOINT: k = ZGOD_PK_SETPOINT;
            `ZGOD_PAR_HEATER:   k = ZGOD_PK_HEATER;
            `ZGOD_PAR_RATE:     k = ZGOD_PK_RATE;
            `ZGOD_PAR_ACTUAL:   k = ZGOD_PK_ACTUAL;
            `ZGOD_PAR_ZSTATUS:  k = ZGOD_PK_ZSTATUS;
            default:            k = ZGOD_PK_CTRL;
        endcase
        return k;
    endfunction

    // ======================================================
    // Bus handshake: one wait cycle per access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_acc = avs_write & ack;
    assign rd_req = avs_read & ~ack;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    // ======================================================
    // Validity edge detection
    assign new_valid = avs_byteenable[3] ? avs_writedata[31:24]
                                         : header[31:24];
    assign trig = wr_acc && avs_address == `ZGOD_OFS_HEADER &&
                  header[31:24] == 8'h00 && new_valid != 8'h00;

    // Header register: order, group, selector, validity
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            header <= `ZGOD_RST_WORD;
        end else if (wr_acc && avs_address == `ZGOD_OFS_HEADER) begin
            header <= merge(header, avs_writedata, avs_byteenable);
        end
    end

    // Dataword pairs, low byte first in each word
    for (genvar g = 0; g < 4; g++) begin : g_words
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                word_pairs[g] <= `ZGOD_RST_WORD;
            end else if (wr_acc && avs_address ==
                         `ZGOD_ADDR_W'(`ZGOD_OFS_WORDS01 + 4*g)) begin
                word_pairs[g] <= merge(word_pairs[g], avs_writedata,
                                       avs_byteenable);
            end
        end
    end

    // Pending flag: set the cycle after the trigger, order runs the cycle after that
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pend <= 1'b0;
        end else begin
            pend <= trig;
        end
    end

    // ======================================================
    // Order latch and decode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_valid <= 1'b0;
            cmd       <= '0;
            cmd.param_kind <= ZGOD_PK_SETPOINT;
        end else begin
            cmd_valid <= pend && (header[7:0] == `ZGOD_ORDER_READ ||
                         header[7:0] == `ZGOD_ORDER_SEND);
            if (pend) begin
                cmd.is_read   <= header[7:0] == `ZGOD_ORDER_READ;
                cmd.is_global <= header[15:8] ==
                                 `ZGOD_GROUP_GLOBAL;
                cmd.zone_base <= ZONE_W'((header[15:8] - 8'h01)
                                 * `ZGOD_ZONES_PER_GRP);
                cmd.param_num  <= header[23:16];
                cmd.param_kind <= param_kind(header[23:16]);
                if (header[7:0] == `ZGOD_ORDER_READ) begin
                    cmd.word_mask <= 8'h00;
                    cmd.words     <= '0;
                end else begin
                    cmd.word_mask <= header[31:24];
                    for (int i = 0; i < 8; i++) begin
                        cmd.words[i] <= header[24+i] ?
                            word_pairs[i/2][(i%2)*16 +: 16] : 16'h0000;
                    end
                end
            end
        end
    end

    // ======================================================
    // Status: bad order flag, last order, count
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            order_err  <= 1'b0;
            last_order <= 8'h00;
            exec_cnt   <= 8'h00;
        end else begin
            if (pend && header[7:0] != `ZGOD_ORDER_READ &&
                header[7:0] != `ZGOD_ORDER_SEND) begin
                order_err <= 1'b1;                             // Set wins
            end else if (wr_acc && avs_address == `ZGOD_OFS_STATUS &&
                         avs_byteenable[1] &&
                         avs_writedata[`ZGOD_ST_ERR_BIT]) begin
                order_err <= 1'b0;
            end
            if (pend) begin
                last_order <= header[7:0];
                exec_cnt   <= exec_cnt + 8'h01;
            end
        end
    end

    // ======================================================
    // Read data, unmapped reads give zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= `ZGOD_RST_WORD;
        end else if (rd_req) begin
            unique case (avs_address)
                `ZGOD_OFS_HEADER:  avs_readdata <= header;
                `ZGOD_OFS_WORDS01: avs_readdata <= word_pairs[0];
                `ZGOD_OFS_WORDS23: avs_readdata <= word_pairs[1];
                `ZGOD_OFS_WORDS45: avs_readdata <= word_pairs[2];
                `ZGOD_OFS_WORDS67: avs_readdata <= word_pairs[3];
                `ZGOD_OFS_STATUS:  avs_readdata <= {8'h00, exec_cnt,
                                     7'h00, order_err, last_order};
                default:           avs_readdata <= `ZGOD_RST_WORD;
            endcase
        end
    end

    // ======================================================
    // Assertions
    sequence s_trigger;
        trig && ((avs_byteenable[0] ? avs_writedata[7:0] : header[7:0])
                 == `ZGOD_ORDER_SEND);
    endsequence

    sequence s_run;
        ##1 pend ##1 cmd_valid;
    endsequence

    bus_ack_a: assert property (@(posedge mclk) disable iff (!rst_b)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");

    exec_edge_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        s_trigger |-> s_run)
        else $error("send order not run two cycles after trigger");

    exec_cause_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid |-> $past(trig, 2))
        else $error("order run without validity edge");

    read_mask_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && cmd.is_read |-> cmd.word_mask == 8'h00 &&
        cmd.words == '0)
        else $error("read order kept datawords");

    send_mask_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && !cmd.is_read |-> cmd.word_mask == $past(header[31:24]))
        else $error("word mask differs from validity byte");

    word_map_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && !cmd.is_read && cmd.word_mask[1] |->
        cmd.words[1] == $past(word_pairs[0][31:16]))
        else $error("dataword two taken from wrong bytes");

    group_glob_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid |-> cmd.is_global == ($past(header[15:8]) == 8'h00))
        else $error("global group decode wrong");

    zone_base_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && !cmd.is_global |->
        cmd.zone_base == ZONE_W'(({3'b000, $past(header[15:8])} - 11'd1) * 8))
        else $error("zone base wrong for group");

    param_set_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && $past(header[23:16]) == 8'h00 |->
        cmd.param_kind == ZGOD_PK_SETPOINT)
        else $error("code zero not setpoint");

    param_top_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && $past(header[23:16]) == 8'hFE |->
        cmd.param_kind == ZGOD_PK_ACTUAL && cmd.param_num == 8'hFE)
        else $error("code 254 not actual value");

    // ======================================================
    // Further order checks
    sequence s_stale_write;
        wr_acc && avs_address == `ZGOD_OFS_HEADER &&
        header[31:24] != 8'h00;
    endsequence

    // A write over a nonzero validity byte starts nothing
    no_retrig_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        s_stale_write |=> !pend)
        else $error("order started on a stale validity byte");

    // Order pulse stands one cycle only
    pulse_once_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid |=> !cmd_valid)
        else $error("order pulse longer than one cycle");

    // Unknown order codes raise the sticky flag, no pulse
    bad_order_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        pend && header[7:0] != `ZGOD_ORDER_READ &&
        header[7:0] != `ZGOD_ORDER_SEND |=> order_err && !cmd_valid)
        else $error("unknown order code not flagged");

    // Codes 1 to 251 are numbered controller parameters
    param_ctrl_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && $past(header[23:16]) inside {[8'h01:8'hFB]} |->
        cmd.param_kind == ZGOD_PK_CTRL &&
        cmd.param_num == $past(header[23:16]))
        else $error("numbered parameter decoded wrong");

    // Code 252 heater current
    param_heat_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && $past(header[23:16]) == `ZGOD_PAR_HEATER |->
        cmd.param_kind == ZGOD_PK_HEATER)
        else $error("code 252 not heater current");

    // Code 253 output rate
    param_rate_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && $past(header[23:16]) == `ZGOD_PAR_RATE |->
        cmd.param_kind == ZGOD_PK_RATE)
        else $error("code 253 not output rate");

    // Code 255 zone status word
    param_stat_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cmd_valid && $past(header[23:16]) == `ZGOD_PAR_ZSTATUS |->
        cmd.param_kind == ZGOD_PK_ZSTATUS)
        else $error("code 255 not zone status");

    // Every dataword follows its own validity flag
    for (genvar n = 0; n < 8; n++) begin : g_word_chk
        word_each_a: assert property (
            @(posedge mclk) disable iff (!rst_b)
            cmd_valid && !cmd.is_read |->
            cmd.words[n] == ($past(header[24+n]) ?
                $past(word_pairs[n/2][(n%2)*16 +: 16]) : 16'h0000))
            else $error("dataword not gated by its flag");
    end

endmodule // zgod_decoder
`default_nettype wire

// ===== rtl/zgod_regs.svh
// Purpose: Offsets, fields and reset values of the zone group decoder
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word each
// Notes:   Definitions only
`ifndef ZGOD_REGS_SVH
`define ZGOD_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define ZGOD_ADDR_W        5
`define ZGOD_OFS_HEADER    5'h00
`define ZGOD_OFS_WORDS01   5'h04
`define ZGOD_OFS_WORDS23   5'h08
`define ZGOD_OFS_WORDS45   5'h0C
`define ZGOD_OFS_WORDS67   5'h10
`define ZGOD_OFS_STATUS    5'h14

// ==========================================================
// Header byte lanes and codes
`define ZGOD_ORDER_READ    8'h01
`define ZGOD_ORDER_SEND    8'h02
`define ZGOD_GROUP_GLOBAL  8'h00
`define ZGOD_PAR_SETPOINT  8'h00
`define ZGOD_PAR_HEATER    8'hFC
`define ZGOD_PAR_RATE      8'hFD
`define ZGOD_PAR_ACTUAL    8'hFE
`define ZGOD_PAR_ZSTATUS   8'hFF
`define ZGOD_ZONES_PER_GRP 8

// ==========================================================
// Status fields and reset values
`define ZGOD_ST_ERR_BIT    8
`define ZGOD_RST_WORD      32'h0000_0000
`define ZGOD_BUS_ACK_CYC   1

`endif

// ===== rtl/zgod_pkg.sv
// Purpose: Types of the zone group decoder
// Assumes: Nothing beyond the shared header
// Notes:   Command travels as one packed struct
package zgod_pkg;

    // ======================================================
    // Parameter kinds, one-hot
    typedef enum logic [5:0] {
        ZGOD_PK_SETPOINT = 6'b000001,
        ZGOD_PK_CTRL     = 6'b000010,
        ZGOD_PK_HEATER   = 6'b000100,
        ZGOD_PK_RATE     = 6'b001000,
        ZGOD_PK_ACTUAL   = 6'b010000,
        ZGOD_PK_ZSTATUS  = 6'b100000
    } zgod_param_e;

    // ======================================================
    // Decoded order handed to the controller core
    typedef struct packed {
        logic              is_read;
        logic              is_global;
        logic [10:0]       zone_base;
        zgod_param_e       param_kind;
        logic [7:0]        param_num;
        logic [7:0]        word_mask;
        logic [7:0][15:0]  words;
    } zgod_cmd_s;

endpackage

// ===== testbench/zgod_master.sv
// Purpose: Fieldbus master model that writes the output image
// Assumes: Avalon-MM slave with waitrequest
// Notes:   Validity byte cleared first and written last
`timescale 1ns/1ps
`default_nettype none
`include "zgod_regs.svh"
module zgod_master (
    input  wire logic        mclk,
    output var  logic [4:0]  avs_address,
    output var  logic        avs_read,
    output var  logic        avs_write,
    output var  logic [31:0] avs_writedata,
    output var  logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // ==================================================
    // Bus cycles
    // Idle bus at time zero
    initial begin
        avs_address    = 5'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
    end

    // One request, held until waitrequest samples low
    task automatic xfer(input logic [4:0] a, input logic wr,
                        input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] q);
        @(posedge mclk);
        avs_address    <= a;
        avs_read       <= ~wr;
        avs_write      <= wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_writedata <= ~d; // Released data stops showing last value
    endtask

    // Whole image: clear validity, header, words, validity last
    task automatic send_image(input logic [7:0] ord, grp, sel, vld,
                              input logic [7:0][15:0] w);
        logic [31:0] q;
        xfer(`ZGOD_OFS_HEADER, 1'b1, 32'h0, 4'h8, q);
        xfer(`ZGOD_OFS_HEADER, 1'b1, {8'h00, sel, grp, ord}, 4'h7, q);
        for (int i = 0; i < 4; i++)
            xfer(5'(4 + 4*i), 1'b1, {w[2*i+1], w[2*i]}, 4'hF, q);
        xfer(`ZGOD_OFS_HEADER, 1'b1, {vld, 24'h0}, 4'h8, q);
    endtask
endmodule // zgod_master
`default_nettype wire

// ===== testbench/tb_zone_group_output_decoder.sv
// Purpose: Self-checking bench of the zone group output decoder
// Assumes: Master model drives the register bus
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "zgod_regs.svh"
module tb_zone_group_output_decoder
    import zgod_pkg::*;
;
    // ==================================================
    // Signals and instances
    logic             mclk;
    logic             rst_b;
    logic [4:0]       avs_address;
    logic             avs_read;
    logic             avs_write;
    logic [31:0]      avs_writedata;
    logic [3:0]       avs_byteenable;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic             cmd_valid;
    zgod_cmd_s        cmd;
    logic [7:0][15:0] w;
    int               failures;
    int               comparisons;

    zgod_decoder i_dut (.mclk(mclk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid),
        .cmd(cmd));

    zgod_master i_master (.mclk(mclk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // ==================================================
    // Helpers
    // Clock of 10 ns
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [127:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // Pulse rises one edge after the taking edge and stands one cycle
    task automatic wait_cmd(input logic exp);
        #1;
        chk("cmd_early", 1'b0, cmd_valid);
        @(posedge mclk);
        #1;
        chk("cmd_valid", exp, cmd_valid);
        @(posedge mclk);
        #1;
        chk("cmd_stands", 1'b0, cmd_valid);
    endtask

    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==================================================
    // Scenarios
    // Read orders over group codes, datawords ignored
    task automatic t_groups();
        logic [7:0] g [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
        foreach (g[i]) begin
            i_master.send_image(`ZGOD_ORDER_READ, g[i], 8'h00, 8'hFF, w);
            wait_cmd(1'b1);
            chk("is_read", 1'b1, cmd.is_read);
            chk("is_global", g[i] == 8'h00, cmd.is_global);
            if (g[i] != 8'h00)
                chk("zone_base", (g[i] - 1) * 8, cmd.zone_base);
            chk("read_mask", 8'h00, cmd.word_mask);
            chk("read_words", 128'h0, cmd.words);
        end
    endtask

    // Every parameter selector class
    task automatic t_params();
        logic [7:0] s [7] = '{8'h00, 8'h01, 8'h02, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
        zgod_param_e k [7] = '{ZGOD_PK_SETPOINT, ZGOD_PK_CTRL, ZGOD_PK_CTRL,
            ZGOD_PK_HEATER, ZGOD_PK_RATE, ZGOD_PK_ACTUAL, ZGOD_PK_ZSTATUS};
        foreach (s[i]) begin
            i_master.send_image(`ZGOD_ORDER_SEND, 8'h02, s[i], 8'h01, w);
            wait_cmd(1'b1);
            chk("param_num", s[i], cmd.param_num);
            chk("kind", k[i], cmd.param_kind);
        end
    endtask

    // Sparse validity masks select words, each flag once set
    task automatic t_words();
        logic [7:0] m [2] = '{8'hA5, 8'h5A};
        foreach (m[j]) begin
            i_master.send_image(`ZGOD_ORDER_SEND, 8'h01, 8'h00, m[j], w);
            wait_cmd(1'b1);
            chk("is_read", 1'b0, cmd.is_read);
            chk("word_mask", m[j], cmd.word_mask);
            for (int i = 0; i < 8; i++)
                chk("word", m[j][i] ? w[i] : 16'h0, cmd.words[i]);
        end
    endtask

    // No retrigger, bad order code, status clear, unmapped read
    task automatic t_refuse();
        logic [31:0] q;
        i_master.xfer(`ZGOD_OFS_HEADER, 1'b1, 32'h5A000201, 4'hF, q);
        wait_cmd(1'b0);
        i_master.xfer(`ZGOD_OFS_HEADER, 1'b0, 32'h0, 4'hF, q);
        chk("header_back", 32'h5A000201, q);
        i_master.send_image(8'h03, 8'h01, 8'h00, 8'h01, w);
        wait_cmd(1'b0);
        i_master.xfer(`ZGOD_OFS_STATUS, 1'b0, 32'h0, 4'hF, q);
        chk("bad_order", 1'b1, q[`ZGOD_ST_ERR_BIT]);
        chk("last_order", 8'h03, q[7:0]);
        chk("run_count", 8'h0F, q[23:16]);
        i_master.xfer(`ZGOD_OFS_STATUS, 1'b1, 32'h100, 4'h2, q);
        i_master.xfer(`ZGOD_OFS_STATUS, 1'b0, 32'h0, 4'hF, q);
        chk("bad_clear", 1'b0, q[`ZGOD_ST_ERR_BIT]);
        i_master.xfer(5'h18, 1'b0, 32'h0, 4'hF, q);
        chk("unmapped", 32'h0, q);
    endtask

    // Main sequence
    initial begin
        failures = 0;
        comparisons = 0;
        rst_b = 1'b0;
        for (int i = 0; i < 8; i++)
            w[i] = 16'hA0B1 + 16'h1111 * i;
        repeat (6) @(posedge mclk);
        chk("reset_valid", 1'b0, cmd_valid);
        rst_b <= 1'b1;
        t_groups();
        $display("t_groups done");
        t_params();
        $display("t_params done");
        t_words();
        $display("t_words done");
        t_refuse();
        $display("t_refuse done");
        conclude();
    end

    // Watchdog
    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule // tb_zone_group_output_decoder
`default_nettype wire
